// [inc/tfs_params.svh]
// Constants of the tape function sequencer: codes, widths and reset values.
`ifndef TFS_PARAMS_SVH
`define TFS_PARAMS_SVH

// ****************************************
// Function codes
// ****************************************
`define TFS_FN_OFFLINE   3'h0
`define TFS_FN_READ      3'h1
`define TFS_FN_WRITE     3'h2
`define TFS_FN_WEOF      3'h3
`define TFS_FN_SPACE_FWD 3'h4
`define TFS_FN_SPACE_REV 3'h5
`define TFS_FN_WRITE_XG  3'h6
`define TFS_FN_REWIND    3'h7

// ****************************************
// Widths, reset values and counts
// ****************************************
`define TFS_CNT_W        16
`define TFS_CNT_RST      16'h0000
`define TFS_CNT_ONE      16'h0001
`define TFS_BYTE_RST     8'h00
`define TFS_UNIT_RST     3'h0
`define TFS_DENS_RST     2'h0
`define TFS_EOF_CHAR     8'h0F
`define TFS_FIFO_DEPTH   16
`define TFS_SYNC_W       15

`endif

// [inc/tfs_pkg.sv]
// Types shared by the tape function sequencer files.
`include "tfs_params.svh"
package tfs_pkg;

	// Sequencer states, one-hot.
	typedef enum logic [6:0] {
		ST_IDLE   = 7'b000_0001,
		ST_WFILL  = 7'b000_0010,
		ST_WWAIT  = 7'b000_0100,
		ST_WTAIL  = 7'b000_1000,
		ST_READ   = 7'b001_0000,
		ST_SPACE  = 7'b010_0000,
		ST_REWIND = 7'b100_0000
	} tfs_state_type;

	// Function codes held in the command register.
	typedef enum logic [2:0] {
		FN_OFFLINE   = `TFS_FN_OFFLINE,
		FN_READ      = `TFS_FN_READ,
		FN_WRITE     = `TFS_FN_WRITE,
		FN_WEOF      = `TFS_FN_WEOF,
		FN_SPACE_FWD = `TFS_FN_SPACE_FWD,
		FN_SPACE_REV = `TFS_FN_SPACE_REV,
		FN_WRITE_XG  = `TFS_FN_WRITE_XG,
		FN_REWIND    = `TFS_FN_REWIND
	} tfs_func_type;

endpackage : tfs_pkg

// [rtl/tfs_fifo.sv]
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module tfs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             core_clk,
	input  wire logic             srst,
	// Filling side.
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// Draining side.
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// Honest full and empty flags from the fill count.
	assign inReady  = (count_r != (AW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData  = mem[rdPtr_r];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Storage array write.
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	chk_fifo_no_overflow: assert property (@(posedge core_clk) disable iff (srst)
		count_r <= (AW+1)'(DEPTH)) else $error("FIFO count above depth.");

endmodule : tfs_fifo
`default_nettype wire

// [rtl/tfs_sequencer.sv]
// Tape function sequencer: command decode, counters and transport handshakes.
`timescale 1ns/1ps
`default_nettype none
`include "tfs_params.svh"
module tfs_sequencer #(
	parameter int CNT_W      = `TFS_CNT_W,
	parameter int FIFO_DEPTH = `TFS_FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic             core_clk,
	input  wire logic             srst,
	// Command loading.
	input  wire logic             cmdLoad,
	input  wire logic [2:0]       cmdUnit,
	input  wire logic [1:0]       cmdDensity,
	input  wire logic [2:0]       cmdFunc,
	input  wire logic             cmdGo,
	// Counter loading.
	input  wire logic             brcLoad,
	input  wire logic [CNT_W-1:0] brcValue,
	input  wire logic             cmaLoad,
	input  wire logic [CNT_W-1:0] cmaValue,
	// Host write data.
	input  wire logic             hostWrValid,
	input  wire logic [7:0]       hostWrData,
	output logic                  hostWrReady,
	// Read data toward memory.
	output logic                  memValid,
	output logic      [7:0]       memData,
	output logic      [CNT_W-1:0] memAddr,
	// Status.
	output logic                  statusReady,
	output logic                  statusIllegal,
	output logic                  statusEndOfTape,
	output logic                  statusUnitReady,
	output logic      [CNT_W-1:0] byteRecordCount,
	output logic      [CNT_W-1:0] memoryAddressCount,
	// Transport control.
	output logic      [2:0]       tpUnit,
	output logic      [1:0]       tpDensity,
	output logic                  tpRun,
	output logic                  tpReverse,
	output logic                  tpHighSpeed,
	output logic                  tpOffline,
	output logic                  tpWriteMode,
	output logic                  tpExtGap,
	output logic                  write_data_ready,
	output logic      [7:0]       tpWrData,
	// Transport pins.
	input  wire logic             write_strobe,
	input  wire logic             tpReadStrobe,
	input  wire logic [7:0]       tpReadData,
	input  wire logic             tpCheckStrobe,
	input  wire logic             tpRecordEnd,
	input  wire logic             tape_start_marker,
	input  wire logic             tpEndOfTape,
	input  wire logic             tpUnitReady
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [`TFS_SYNC_W-1:0] pinRaw;
	logic [`TFS_SYNC_W-1:0] pinMeta_r;
	logic [`TFS_SYNC_W-1:0] pinSync_r;
	logic [3:0]             pinPrev_r;
	logic                   wrsEdge;
	logic                   rdsEdge;
	logic                   chkEdge;
	logic                   recEdge;
	logic [7:0]             rdData;
	logic                   atStart;
	logic                   atEnd;
	logic                   unitRdy;

	assign pinRaw = {tpReadData, tpUnitReady, tpEndOfTape, tape_start_marker,
		tpRecordEnd, tpCheckStrobe, tpReadStrobe, write_strobe};

	// Two flops per pin, then a third stage for the edge detectors.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
			pinPrev_r <= '0;
		end else begin
			pinMeta_r <= pinRaw;
			pinSync_r <= pinMeta_r;
			pinPrev_r <= pinSync_r[3:0];
		end
	end

	// Rising edges of the strobes and settled pin levels.
	assign wrsEdge = pinSync_r[0] && !pinPrev_r[0];
	assign rdsEdge = pinSync_r[1] && !pinPrev_r[1];
	assign chkEdge = pinSync_r[2] && !pinPrev_r[2];
	assign recEdge = pinSync_r[3] && !pinPrev_r[3];
	assign atStart = pinSync_r[4];
	assign atEnd   = pinSync_r[5];
	assign unitRdy = pinSync_r[6];
	assign rdData  = pinSync_r[14:7];

	// ****************************************
	// Command register
	// ****************************************
	logic [2:0]           unit_r;
	logic [1:0]           density_r;
	tfs_pkg::tfs_func_type func_r;

	// Program-loaded unit, density and function, frozen while busy.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			unit_r    <= `TFS_UNIT_RST;
			density_r <= `TFS_DENS_RST;
			func_r    <= tfs_pkg::FN_OFFLINE;
		end else if (cmdLoad && statusReady) begin
			unit_r    <= cmdUnit;
			density_r <= cmdDensity;
			func_r    <= tfs_pkg::tfs_func_type'(cmdFunc);
		end
	end

	// Tells whether a function moves data to the heads.
	function automatic logic isWrite(input tfs_pkg::tfs_func_type f);
		isWrite = (f == tfs_pkg::FN_WRITE) || (f == tfs_pkg::FN_WRITE_XG) ||
			(f == tfs_pkg::FN_WEOF);
	endfunction : isWrite

	// Tells whether a function only repositions by records.
	function automatic logic isSpace(input tfs_pkg::tfs_func_type f);
		isSpace = (f == tfs_pkg::FN_SPACE_FWD) || (f == tfs_pkg::FN_SPACE_REV);
	endfunction : isSpace

	// ****************************************
	// Sequencer state
	// ****************************************
	tfs_pkg::tfs_state_type state_r;
	tfs_pkg::tfs_state_type state_nxt;
	logic                   startOk;
	logic [CNT_W-1:0]       brcInc;
	logic                   brcLast;
	logic                   fifoValid;
	logic [7:0]             fifoData;
	logic                   fifoPop;
	logic                   eofDone_r;

	// A go is accepted only when idle with the selected unit ready.
	assign startOk = cmdGo && statusReady && unitRdy;
	assign brcInc  = byteRecordCount + CNT_W'(`TFS_CNT_ONE);
	assign brcLast = (brcInc == CNT_W'(`TFS_CNT_RST));

	// Next-state decode.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			tfs_pkg::ST_IDLE: begin
				if (startOk) begin
					case (func_r)
						tfs_pkg::FN_READ:      state_nxt = tfs_pkg::ST_READ;
						tfs_pkg::FN_WRITE,
						tfs_pkg::FN_WRITE_XG,
						tfs_pkg::FN_WEOF:      state_nxt = tfs_pkg::ST_WFILL;
						tfs_pkg::FN_SPACE_FWD,
						tfs_pkg::FN_SPACE_REV: state_nxt = tfs_pkg::ST_SPACE;
						tfs_pkg::FN_REWIND:    state_nxt = tfs_pkg::ST_REWIND;
						default:               state_nxt = tfs_pkg::ST_IDLE;
					endcase
				end
			end
			tfs_pkg::ST_WFILL: begin
				if (func_r == tfs_pkg::FN_WEOF || fifoValid) begin
					state_nxt = tfs_pkg::ST_WWAIT;
				end
			end
			tfs_pkg::ST_WWAIT: begin
				if (wrsEdge) begin
					state_nxt = (brcLast || eofDone_r || func_r == tfs_pkg::FN_WEOF) ?
						tfs_pkg::ST_WTAIL : tfs_pkg::ST_WFILL;
				end
			end
			tfs_pkg::ST_WTAIL: begin
				if (recEdge) begin
					state_nxt = tfs_pkg::ST_IDLE;
				end
			end
			tfs_pkg::ST_READ: begin
				if (recEdge) begin
					state_nxt = tfs_pkg::ST_IDLE;
				end
			end
			tfs_pkg::ST_SPACE: begin
				if (recEdge && brcLast) begin
					state_nxt = tfs_pkg::ST_IDLE;
				end
			end
			tfs_pkg::ST_REWIND: begin
				if (atStart) begin
					state_nxt = tfs_pkg::ST_IDLE;
				end
			end
			default: state_nxt = tfs_pkg::ST_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= tfs_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Write data path
	// ****************************************
	// Bus bytes queue in the FIFO; the buffer takes one per character.
	assign fifoPop = (state_r == tfs_pkg::ST_WFILL) && (func_r != tfs_pkg::FN_WEOF);

	tfs_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.srst     (srst),
		.inValid  (hostWrValid),
		.inData   (hostWrData),
		.inReady  (hostWrReady),
		.outValid (fifoValid),
		.outData  (fifoData),
		.outReady (fifoPop)
	);

	// Data buffer toward the write heads; end-of-file uses the mark character.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tpWrData <= `TFS_BYTE_RST;
		end else if (state_r == tfs_pkg::ST_WFILL) begin
			if (func_r == tfs_pkg::FN_WEOF) begin
				tpWrData <= `TFS_EOF_CHAR;
			end else if (fifoValid) begin
				tpWrData <= fifoData;
			end
		end
	end

	// End-of-file writes a single character record.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			eofDone_r <= 1'b0;
		end else begin
			eofDone_r <= (state_r != tfs_pkg::ST_IDLE) && (func_r == tfs_pkg::FN_WEOF);
		end
	end

	// Ready level stands while a buffered character awaits its strobe.
	assign write_data_ready = (state_r == tfs_pkg::ST_WWAIT);

	// ****************************************
	// Counters
	// ****************************************
	logic transferTick;
	logic readStop_r;

	// One tick per read strobe up to a check strobe or the last byte, written byte or spaced record.
	assign transferTick = (state_r == tfs_pkg::ST_WWAIT && wrsEdge) ||
		(state_r == tfs_pkg::ST_READ && rdsEdge && !readStop_r) ||
		(state_r == tfs_pkg::ST_SPACE && recEdge);

	// Byte/record counter, loaded with a negated count by the program.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			byteRecordCount <= CNT_W'(`TFS_CNT_RST);
		end else if (brcLoad && statusReady) begin
			byteRecordCount <= brcValue;
		end else if (transferTick) begin
			byteRecordCount <= brcInc;
		end
	end

	// Memory address counter, never advanced while spacing.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			memoryAddressCount <= CNT_W'(`TFS_CNT_RST);
		end else if (cmaLoad && statusReady) begin
			memoryAddressCount <= cmaValue;
		end else if (transferTick && !isSpace(func_r)) begin
			memoryAddressCount <= memoryAddressCount + CNT_W'(`TFS_CNT_ONE);
		end
	end

	// ****************************************
	// Read data path
	// ****************************************
	// Check characters and anything after the last byte are not stored.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			readStop_r <= 1'b0;
		end else if (state_r != tfs_pkg::ST_READ) begin
			readStop_r <= 1'b0;
		end else if (chkEdge || (rdsEdge && brcLast)) begin
			readStop_r <= 1'b1;
		end
	end

	// Byte and its address presented to memory for one cycle.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			memValid <= 1'b0;
			memData  <= `TFS_BYTE_RST;
			memAddr  <= CNT_W'(`TFS_CNT_RST);
		end else begin
			memValid <= state_r == tfs_pkg::ST_READ && rdsEdge && !readStop_r && !chkEdge;
			if (state_r == tfs_pkg::ST_READ && rdsEdge && !readStop_r) begin
				memData <= rdData;
				memAddr <= memoryAddressCount;
			end
		end
	end

	// ****************************************
	// Transport control
	// ****************************************
	// Motion, direction and mode levels toward the master transport.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tpRun       <= 1'b0;
			tpReverse   <= 1'b0;
			tpHighSpeed <= 1'b0;
			tpWriteMode <= 1'b0;
			tpExtGap    <= 1'b0;
		end else begin
			tpRun       <= state_nxt != tfs_pkg::ST_IDLE;
			tpReverse   <= (state_nxt == tfs_pkg::ST_REWIND) ||
				(state_nxt == tfs_pkg::ST_SPACE && func_r == tfs_pkg::FN_SPACE_REV);
			tpHighSpeed <= state_nxt == tfs_pkg::ST_REWIND;
			tpWriteMode <= (state_nxt != tfs_pkg::ST_IDLE) && isWrite(func_r);
			tpExtGap    <= (state_nxt != tfs_pkg::ST_IDLE) &&
				(func_r == tfs_pkg::FN_WRITE_XG || func_r == tfs_pkg::FN_WEOF);
		end
	end

	// Off-line pulse hands the unit to local rewind and frees the controller.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tpOffline <= 1'b0;
		end else begin
			tpOffline <= startOk && func_r == tfs_pkg::FN_OFFLINE;
		end
	end

	// Unit and density lines follow the command register.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tpUnit    <= `TFS_UNIT_RST;
			tpDensity <= `TFS_DENS_RST;
		end else begin
			tpUnit    <= unit_r;
			tpDensity <= density_r;
		end
	end

	// ****************************************
	// Status
	// ****************************************
	// Illegal flag sets on a refused go and clears on the next accepted one.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			statusIllegal <= 1'b0;
		end else if (cmdGo && !startOk) begin
			statusIllegal <= 1'b1;
		end else if (startOk) begin
			statusIllegal <= 1'b0;
		end
	end

	// Tape state of the selected unit only.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			statusEndOfTape <= 1'b0;
			statusUnitReady <= 1'b0;
		end else begin
			statusEndOfTape <= atEnd;
			statusUnitReady <= unitRdy;
		end
	end

	assign statusReady = (state_r == tfs_pkg::ST_IDLE);

	// ****************************************
	// Checks
	// ****************************************
	chk_wdr_drop_last: assert property (@(posedge core_clk) disable iff (srst)
		(write_data_ready && wrsEdge && brcLast) |=> !write_data_ready [*2])
		else $error("Ready level stayed up after last strobe.");
	chk_brc_step: assert property (@(posedge core_clk) disable iff (srst)
		(transferTick && !brcLoad) |=> byteRecordCount == $past(byteRecordCount) + 1'b1)
		else $error("Counter did not step on transfer.");
	chk_space_no_mem: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == tfs_pkg::ST_SPACE) |-> !memValid && !tpWriteMode)
		else $error("Spacing touched memory or tape.");
	chk_space_rev_dir: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == tfs_pkg::ST_SPACE && func_r == tfs_pkg::FN_SPACE_REV) |-> tpReverse)
		else $error("Reverse spacing ran forward.");
	chk_rewind_fast: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == tfs_pkg::ST_REWIND && state_nxt == tfs_pkg::ST_REWIND)
		|=> tpHighSpeed && tpReverse)
		else $error("Rewind not fast reverse.");
	chk_check_not_stored: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == tfs_pkg::ST_READ && chkEdge) |=> !memValid)
		else $error("Check character stored.");
	chk_offline_pulse: assert property (@(posedge core_clk) disable iff (srst)
		tpOffline |-> $past(func_r) == tfs_pkg::FN_OFFLINE && statusReady)
		else $error("Off-line pulse without code 0.");
	chk_go_refused: assert property (@(posedge core_clk) disable iff (srst)
		(cmdGo && !startOk) |=> statusIllegal && $stable(state_r))
		else $error("Refused go not flagged.");
	chk_erase_gap: assert property (@(posedge core_clk) disable iff (srst)
		(write_data_ready && func_r == tfs_pkg::FN_WRITE_XG) |-> tpExtGap)
		else $error("Extended gap missing.");
	chk_addr_step: assert property (@(posedge core_clk) disable iff (srst)
		memValid |-> memoryAddressCount == memAddr + 1'b1)
		else $error("Address counter not one ahead.");

	cov_write_done: cover property (@(posedge core_clk) disable iff (srst)
		state_r == tfs_pkg::ST_WTAIL ##1 state_r == tfs_pkg::ST_IDLE);
	cov_read_byte: cover property (@(posedge core_clk) disable iff (srst) memValid);
	cov_space_done: cover property (@(posedge core_clk) disable iff (srst)
		state_r == tfs_pkg::ST_SPACE ##1 state_r == tfs_pkg::ST_IDLE);
	cov_rewind_done: cover property (@(posedge core_clk) disable iff (srst)
		state_r == tfs_pkg::ST_REWIND ##1 state_r == tfs_pkg::ST_IDLE);

endmodule : tfs_sequencer
`default_nettype wire

// [tb/tfs_transport_model.sv]
// Behavioural master transport that answers the sequencer's transport pins.
`timescale 1ns/1ps
`default_nettype none
module tfs_transport_model (
	// Clock.
	input  wire logic       core_clk,
	// Requests from the sequencer.
	input  wire logic       tpRun,
	input  wire logic       tpWriteMode,
	input  wire logic       tpHighSpeed,
	input  wire logic       write_data_ready,
	input  wire logic [7:0] tpWrData,
	// Pacing set by the bench.
	input  wire logic [7:0] strobeGap,
	input  wire logic [7:0] recLen,
	// Pins toward the sequencer.
	output logic            write_strobe,
	output logic            tpReadStrobe,
	output logic [7:0]      tpReadData,
	output logic            tpCheckStrobe,
	output logic            tpRecordEnd,
	output logic            tape_start_marker
);
	logic [7:0] wrQ[$];
	int         idleCnt;

	// Holds a pin high, then low, three clocks each so the synchroniser sees one edge.
	task automatic pulse(ref logic pin);
		pin = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 pin = 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask : pulse

	// Serves rewinds, write characters and read or spaced records while motion is asked.
	initial begin
		{write_strobe, tpReadStrobe, tpCheckStrobe, tpRecordEnd, tape_start_marker} = '0;
		tpReadData = 8'h00;
		idleCnt = 0;
		forever begin
			@(posedge core_clk);
			#1;
			if (tpRun && tpHighSpeed) begin
				repeat (20) @(posedge core_clk);
				#1 tape_start_marker = 1'b1;
				while (tpRun) @(posedge core_clk);
				#1 tape_start_marker = 1'b0;
			end else if (tpRun && tpWriteMode && write_data_ready) begin
				repeat (strobeGap) @(posedge core_clk);
				#1 wrQ.push_back(tpWrData);
				pulse(write_strobe);
				idleCnt = 0;
			end else if (tpRun && tpWriteMode) begin
				idleCnt++;
				if (idleCnt == 10) begin
					pulse(tpRecordEnd);
					idleCnt = 0;
				end
			end else if (tpRun) begin
				for (int i = 0; i < recLen; i++) begin
					tpReadData = 8'h40 + 8'(i);
					pulse(tpReadStrobe);
					tpReadData = ~tpReadData; // The bus does not keep a stale character.
				end
				pulse(tpCheckStrobe);
				tpReadData = 8'hEE;
				pulse(tpReadStrobe);
				tpReadData = 8'h11;
				pulse(tpRecordEnd);
			end else begin
				idleCnt = 0;
			end
		end
	end
endmodule : tfs_transport_model
`default_nettype wire

// [tb/tfs_sequencer_bench.sv]
// Self-checking bench for the tape function sequencer against the transport model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin \
	err_total++; $display("MISMATCH %0t %s", $time, m); end end
module tfs_sequencer_bench;
	logic        core_clk, srst, cmdLoad, cmdGo, brcLoad, cmaLoad, hostWrValid, hostWrReady;
	logic [2:0]  cmdUnit, cmdFunc, tpUnit;
	logic [1:0]  cmdDensity, tpDensity;
	logic [7:0]  hostWrData, memData, tpWrData, tpReadData, strobeGap, recLen;
	logic [15:0] brcValue, cmaValue, memAddr, byteRecordCount, memoryAddressCount;
	logic        memValid, statusReady, statusIllegal, statusEndOfTape, statusUnitReady;
	logic        tpRun, tpReverse, tpHighSpeed, tpOffline, tpWriteMode, tpExtGap;
	logic        write_data_ready, write_strobe, tpReadStrobe, tpCheckStrobe, tpRecordEnd;
	logic        tape_start_marker, tpEndOfTape, tpUnitReady;
	logic [23:0] memQ[$];
	int          err_total, checks_done;

	// ****************************************
	// Clock, design and partner
	// ****************************************
	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;

	tfs_sequencer DUT (.core_clk, .srst, .cmdLoad, .cmdUnit, .cmdDensity, .cmdFunc, .cmdGo,
		.brcLoad, .brcValue, .cmaLoad, .cmaValue, .hostWrValid, .hostWrData, .hostWrReady,
		.memValid, .memData, .memAddr, .statusReady, .statusIllegal, .statusEndOfTape,
		.statusUnitReady, .byteRecordCount, .memoryAddressCount, .tpUnit, .tpDensity, .tpRun,
		.tpReverse, .tpHighSpeed, .tpOffline, .tpWriteMode, .tpExtGap, .write_data_ready,
		.tpWrData, .write_strobe, .tpReadStrobe, .tpReadData, .tpCheckStrobe, .tpRecordEnd,
		.tape_start_marker, .tpEndOfTape, .tpUnitReady);
	tfs_transport_model tp (.core_clk, .tpRun, .tpWriteMode, .tpHighSpeed, .write_data_ready,
		.tpWrData, .strobeGap, .recLen, .write_strobe, .tpReadStrobe, .tpReadData,
		.tpCheckStrobe, .tpRecordEnd, .tape_start_marker);

	// Memory side accepts every store pulse and keeps address and byte.
	always @(posedge core_clk) if (memValid === 1'b1) memQ.push_back({memAddr, memData});

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	// Loads command and counters, then issues go one cycle later.
	task automatic start(logic [2:0] f, logic [15:0] brc, logic [15:0] cma);
		tick(1);
		{cmdLoad, brcLoad, cmaLoad} = 3'b111;
		{cmdUnit, cmdDensity, cmdFunc} = {f, f[1:0], f};
		brcValue = brc;
		cmaValue = cma;
		tick(1);
		{cmdLoad, brcLoad, cmaLoad, cmdGo} = 4'b0001;
		tick(1);
		cmdGo = 1'b0;
	endtask : start

	task automatic check_run(logic [2:0] f, logic wr, logic rev, logic gap);
		tick(2);
		`CHK(tpUnit, f, "unit select")
		`CHK(tpDensity, f[1:0], "density")
		`CHK(tpRun, 1'b1, "motion")
		`CHK(tpWriteMode, wr, "write mode")
		`CHK(tpReverse, rev, "direction")
		`CHK(tpHighSpeed, f == 3'h7, "high speed")
		`CHK(tpExtGap, gap, "erase gap")
		`CHK(statusReady, 1'b0, "busy")
	endtask : check_run

	task automatic wait_idle();
		int n;
		n = 0;
		while (statusReady !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		`CHK(statusReady, 1'b1, "operation end")
		tick(40);
	endtask : wait_idle

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic do_notready();
		tpUnitReady = 1'b0;
		tick(4);
		`CHK(statusUnitReady, 1'b0, "unit not ready")
		start(3'h2, 16'hFFFF, 16'h0000);
		tick(1);
		`CHK(statusIllegal, 1'b1, "go refused")
		`CHK(tpRun, 1'b0, "no motion")
		{tpEndOfTape, tpUnitReady} = 2'b11;
		tick(4);
		`CHK(statusEndOfTape, 1'b1, "end of tape")
		`CHK(statusUnitReady, 1'b1, "unit ready")
		tpEndOfTape = 1'b0;
		$display("test not ready done");
	endtask : do_notready

	// Fills the buffer except for end-of-file, then writes while the transport stalls between strobes.
	task automatic do_write(logic [2:0] f, int n, logic [7:0] gap);
		logic [15:0] cnt;
		cnt = 16'(n);
		strobeGap = gap;
		tp.wrQ.delete();
		hostWrValid = (f != 3'h3);
		for (int i = 0; i < n && f != 3'h3; i++) begin
			hostWrData = 8'hA0 + 8'(i);
			tick(1);
		end
		hostWrValid = 1'b0;
		if (n == 16) `CHK(hostWrReady, 1'b0, "buffer full")
		start(f, 16'h0000 - cnt, 16'h0100);
		check_run(f, 1'b1, 1'b0, f != 3'h2);
		wait_idle();
		`CHK(tp.wrQ.size(), n, "character count")
		for (int i = 0; i < tp.wrQ.size(); i++)
			`CHK(tp.wrQ[i], (f == 3'h3) ? 8'h0F : 8'hA0 + 8'(i), "character")
		`CHK(byteRecordCount, 16'h0000, "count end")
		if (f != 3'h3) `CHK(memoryAddressCount, 16'h0100 + cnt, "address")
		`CHK(write_data_ready, 1'b0, "ready dropped")
		`CHK(hostWrReady, 1'b1, "buffer drained")
		$display("test write %0d done", f);
	endtask : do_write

	task automatic do_read(logic [15:0] cnt, logic [7:0] len);
		int k;
		k = (cnt < len) ? cnt : len;
		recLen = len;
		memQ.delete();
		start(3'h1, 16'h0000 - cnt, 16'h0200);
		check_run(3'h1, 1'b0, 1'b0, 1'b0);
		wait_idle();
		`CHK(memQ.size(), k, "stored bytes")
		for (int i = 0; i < k; i++)
			`CHK(memQ[i], {16'h0200 + 16'(i), 8'h40 + 8'(i)}, "stored byte")
		`CHK(memoryAddressCount, 16'h0200 + 16'(k), "address")
		`CHK(byteRecordCount, 16'(k) - cnt, "count")
		$display("test read %0d done", cnt);
	endtask : do_read

	task automatic do_space(logic [2:0] f);
		recLen = 8'h02;
		memQ.delete();
		start(f, 16'hFFFD, 16'h0300);
		check_run(f, 1'b0, f == 3'h5, 1'b0);
		wait_idle();
		`CHK(byteRecordCount, 16'h0000, "records")
		`CHK(memoryAddressCount, 16'h0300, "address kept")
		`CHK(memQ.size(), 0, "no stores")
		$display("test space %0d done", f);
	endtask : do_space

	task automatic do_rewind();
		memQ.delete();
		start(3'h7, 16'h1234, 16'h0400);
		check_run(3'h7, 1'b0, 1'b1, 1'b0);
		cmdGo = 1'b1;
		tick(1);
		cmdGo = 1'b0;
		tick(1);
		`CHK(statusIllegal, 1'b1, "go while busy")
		wait_idle();
		`CHK(statusIllegal, 1'b1, "refusal kept")
		`CHK(byteRecordCount, 16'h1234, "count kept")
		`CHK(memQ.size(), 0, "no stores")
		$display("test rewind done");
	endtask : do_rewind

	task automatic do_offline();
		logic seen;
		seen = 1'b0;
		start(3'h0, 16'h0000, 16'h0000);
		repeat (4) begin
			seen |= (tpOffline === 1'b1);
			tick(1);
		end
		`CHK(seen, 1'b1, "offline pulse")
		`CHK(tpWriteMode, 1'b0, "no transfer")
		`CHK(statusIllegal, 1'b0, "accepted go")
		wait_idle();
		$display("test offline done");
	endtask : do_offline

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	// Cuts a hang short well beyond the expected run time.
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		$display("MISMATCH %0t watchdog expired", $time);
		finish_test();
	end

	// Resets the design, then runs every scenario in turn.
	initial begin
		{srst, cmdLoad, cmdGo, brcLoad, cmaLoad, hostWrValid} = 6'b100000;
		{cmdUnit, cmdDensity, cmdFunc, hostWrData} = '0;
		{brcValue, cmaValue, strobeGap, recLen} = '0;
		{tpEndOfTape, tpUnitReady} = 2'b01;
		{err_total, checks_done} = '0;
		tick(12);
		srst = 1'b0;
		`CHK(statusReady, 1'b1, "idle after reset")
		`CHK(write_data_ready, 1'b0, "ready low after reset")
		`CHK(tpRun, 1'b0, "no motion after reset")
		do_notready();
		do_write(3'h2, 16, 8'h04);
		do_write(3'h6, 3, 8'h00);
		do_write(3'h3, 1, 8'h02);
		do_read(16'h0004, 8'h06);
		do_read(16'h0008, 8'h03);
		do_space(3'h4);
		do_space(3'h5);
		do_rewind();
		do_offline();
		finish_test();
	end
endmodule : tfs_sequencer_bench
`default_nettype wire
